// *** hw/rmqo_pkg.sv ***
// Constants and types for the reference mark / quadrature output block.
// Assumes a single 50 MHz pclk domain and an APB register slave.
// Behaviour
// R01 - Reference from index pair or switch
// R02 - Switch rising edge starts referencing
// R03 - Reference lasts one quadrature transition minimum
// R04 - Ignore further triggers for 1 second
// R05 - No velocity limit while referencing
// R06 - Reference only accepted while axis moving
// R07 - Output digital quadrature or analogue format
// R08 - Output carries A, B, index, error
// R09 - Output resolution selectable per configuration
// R10 - Error via line or drive withdrawal
// R11 - Encoder type selected from three kinds
// R12 - Controller handles six outputs, three inputs
// R13 - Controller holds reset 100 ms minimum
// R14 - Decode quadrature into signed counts
package rmqo_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned LOCKOUT_MS      = 1000;
    localparam int unsigned LOCKOUT_CYC     = CLK_HZ / 1000 * LOCKOUT_MS;
    localparam int unsigned RESET_MIN_MS    = 100;
    localparam int unsigned RESET_MIN_CYC   = CLK_HZ / 1000 * RESET_MIN_MS;
    localparam int unsigned MOTION_WIN_CYC  = 4096;

    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_POS      = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
    localparam logic [7:0] ADDR_DIV      = 8'h18;

    // Control register fields
    localparam int CTRL_REF_SRC  = 0;
    localparam int CTRL_OUT_FMT  = 1;
    localparam int CTRL_ENC_LSB  = 2;
    localparam int CTRL_RES_LSB  = 4;
    localparam int CTRL_ERR_MODE = 7;
    localparam int CTRL_ENABLE   = 8;
    localparam logic [8:0] CTRL_RST = 9'h100;
    localparam logic [7:0] DIV_RST  = 8'h01;

    // Event bits
    localparam int EV_REF   = 0;
    localparam int EV_ERR   = 1;
    localparam int EV_IGN   = 2;
    localparam int EV_STILL = 3;
    localparam int EV_W     = 4;

    typedef enum logic [1:0] {
        RMQO_ENC_LASER_A,
        RMQO_ENC_LASER_B,
        RMQO_ENC_SCALE,
        RMQO_ENC_BAD
    } rmqo_enc_t;
endpackage : rmqo_pkg

// *** hw/rmqo_quad_decode.sv ***
// Quadrature decoder: signed count, direction and valid/illegal edge flags.
// Assumes a and b already synchronous to pclk.
module rmqo_quad_decode
    import rmqo_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        qa,
    input  wire logic        qb,
    output logic             step,
    output logic             dir_up,
    output logic             illegal,
    output logic      [31:0] count
);
    typedef struct packed {
        logic [1:0]  prev;
        logic [31:0] cnt;
        logic        step;
        logic        up;
        logic        bad;
    } rmqo_qd_t;

    rmqo_qd_t s_r;
    rmqo_qd_t s_nxt;

    always_comb begin
        logic [1:0] cur;
        cur        = {qa, qb};
        s_nxt      = s_r;
        s_nxt.prev = cur;
        s_nxt.step = 1'b0;
        s_nxt.bad  = 1'b0;
        // Gray sequence 00-10-11-01 counts up
        case ({s_r.prev, cur})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
                s_nxt.step = 1'b1; // R14
                s_nxt.up   = 1'b1;
                s_nxt.cnt  = s_r.cnt + 32'h00000001;
            end
            4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
                s_nxt.step = 1'b1; // R14
                s_nxt.up   = 1'b0;
                s_nxt.cnt  = s_r.cnt - 32'h00000001;
            end
            4'b0011, 4'b1100, 4'b0110, 4'b1001: begin
                s_nxt.bad = 1'b1;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign step    = s_r.step;
    assign dir_up  = s_r.up;
    assign illegal = s_r.bad;
    assign count   = s_r.cnt;
endmodule : rmqo_quad_decode

// *** hw/rmqo_top.sv ***
// Reference mark handling and quadrature output toward the axis controller.
// Assumes encoder and switch inputs synchronous to pclk; APB slave on pclk.
//
// The implementer's own choices: the APB slave port and the register offsets.
module rmqo_top
    import rmqo_pkg::*;
#(
    parameter int unsigned LOCKOUT_CYCLES = LOCKOUT_CYC,
    parameter int unsigned CLR_MIN_CYCLES = RESET_MIN_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_index,
    input  wire logic        ref_switch,
    input  wire logic        err_clear_n,
    input  wire logic        enc_fault,
    output logic             out_a,
    output logic             out_b,
    output logic             out_index,
    output logic             out_error_n,
    output logic             out_drive_oe_n,
    output logic             ana_sel,
    output logic [1:0]       ana_phase,
    output logic             irq
);
    typedef struct packed {
        logic [8:0]  ctrl;
        logic [7:0]  div;
        logic [4:0]  ev;
        logic [4:0]  en;
        logic [31:0] rdata;
        logic        ref_q;
        logic [31:0] lock;
        logic [12:0] still;
        logic        err;
        logic [31:0] clr_cnt;
        logic [1:0]  opos;
        logic [7:0]  pre;
        logic [7:0]  acc;
        logic        idx;
        logic [31:0] ref_pos;
        logic        armed;
    } rmqo_st_t;

    rmqo_st_t s_r;
    rmqo_st_t s_nxt;

    logic        step;
    logic        dir_up;
    logic        illegal;
    logic [31:0] count;

    rmqo_quad_decode u_dec (
        .pclk    (pclk),
        .presetn (presetn),
        .qa      (enc_a),
        .qb      (enc_b),
        .step    (step),
        .dir_up  (dir_up),
        .illegal (illegal),
        .count   (count)
    );

    // Output scale: steps per output edge, 1,2,4..128 by field value
    function automatic logic [7:0] res_div(input logic [2:0] sel, input rmqo_enc_t enc);
        logic [7:0] d;
        d = 8'h01 << sel;
        // Coarse scale gets no coarser than 32 steps per output edge
        if (enc == RMQO_ENC_SCALE && sel > 3'h5) begin
            d = 8'h20;
        end
        return d;
    endfunction : res_div

    function automatic logic [1:0] gray_next(input logic [1:0] g, input logic up);
        logic [1:0] r;
        case ({up, g})
            3'b100:  r = 2'b10;
            3'b110:  r = 2'b11;
            3'b111:  r = 2'b01;
            3'b101:  r = 2'b00;
            3'b000:  r = 2'b01;
            3'b001:  r = 2'b11;
            3'b011:  r = 2'b10;
            default: r = 2'b00;
        endcase
        return r;
    endfunction : gray_next

    logic      access;
    logic      wr;
    logic      ref_in;
    logic      trig;
    logic      moving;
    rmqo_enc_t enc;
    logic [4:0] ev_set;
    logic [4:0] clr_w;

    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign enc    = rmqo_enc_t'(s_r.ctrl[CTRL_ENC_LSB +: 2]); // R11
    assign ref_in = s_r.ctrl[CTRL_REF_SRC] ? ref_switch : enc_index; // R01
    assign moving = s_r.still != MOTION_WIN_CYC[12:0]; // R06
    assign trig   = ref_in && !s_r.ref_q; // R02
    assign clr_w  = (wr && paddr == ADDR_IRQ_CLR) ? pwdata[4:0] : 5'h00;

    always_comb begin
        s_nxt       = s_r;
        ev_set      = 5'h00;
        s_nxt.ref_q = ref_in;
        s_nxt.idx   = 1'b0;

        // Motion detector: counts idle cycles since last edge
        if (step) begin
            s_nxt.still = '0;
        end else if (moving) begin
            s_nxt.still = s_r.still + 13'h0001;
        end

        // Referencing: edge, then 1 s lockout; speed is never checked
        s_nxt.armed = 1'b0;
        if (s_r.lock != 32'h0) begin
            s_nxt.lock = s_r.lock - 32'h00000001; // R04
            if (trig) begin
                ev_set[EV_IGN] = 1'b1; // R04
            end
        end else if ((trig || s_r.armed) && step) begin
            // Mark must overlap a transition of input quadrature
            s_nxt.lock     = LOCKOUT_CYCLES; // R04 R03 R05
            s_nxt.idx      = 1'b1;
            s_nxt.ref_pos  = count;
            ev_set[EV_REF] = 1'b1;
        end else if (trig && !moving) begin
            ev_set[EV_STILL] = 1'b1; // R06
        end else if (trig || s_r.armed) begin
            // Slow axis: keep the mark until the next input step
            s_nxt.armed = ref_in; // R03
        end

        // Error latch: cleared only by a long low on the clear line
        if (illegal || enc_fault || enc == RMQO_ENC_BAD) begin
            s_nxt.err = 1'b1;
            if (!s_r.err) begin
                ev_set[EV_ERR] = 1'b1;
            end
        end else if (s_r.clr_cnt >= CLR_MIN_CYCLES) begin
            s_nxt.err = 1'b0; // R13
        end
        s_nxt.clr_cnt = err_clear_n ? 32'h0
                      : (s_r.clr_cnt >= CLR_MIN_CYCLES ? s_r.clr_cnt
                                                        : s_r.clr_cnt + 32'h00000001);

        // Output synthesis: one output edge per res_div steps
        if (step && s_r.ctrl[CTRL_ENABLE] && !s_r.err) begin
            if (s_r.acc + 8'h01 >= res_div(s_r.ctrl[CTRL_RES_LSB +: 3], enc)) begin // R09
                s_nxt.acc  = 8'h00;
                s_nxt.opos = gray_next(s_r.opos, dir_up); // R07
            end else begin
                s_nxt.acc = s_r.acc + 8'h01;
            end
        end

        // Sticky events; set beats clear
        s_nxt.ev = (s_r.ev & ~clr_w) | ev_set;

        // APB
        if (wr) begin
            case (paddr)
                ADDR_CTRL:   s_nxt.ctrl = pwdata[8:0];
                ADDR_IRQ_EN: s_nxt.en   = pwdata[4:0];
                ADDR_DIV:    s_nxt.div  = pwdata[7:0];
                default: begin
                end
            endcase
        end
        // Read word taken in setup so prdata comes from a flop
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_CTRL:     s_nxt.rdata = {23'h0, s_r.ctrl};
                ADDR_STATUS:   s_nxt.rdata = {28'h0, moving, s_r.lock != 32'h0,
                                              s_r.err, s_r.opos[0]};
                ADDR_POS:      s_nxt.rdata = count;
                ADDR_IRQ_STAT: s_nxt.rdata = {27'h0, s_r.ev};
                ADDR_IRQ_EN:   s_nxt.rdata = {27'h0, s_r.en};
                ADDR_DIV:      s_nxt.rdata = {24'h0, s_r.div};
                default:       s_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r      <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.div  <= DIV_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Zero wait: read word already captured during setup
    assign prdata  = s_r.rdata;
    assign pready  = 1'b1;
    assign pslverr = access && !(paddr == ADDR_CTRL || paddr == ADDR_STATUS
                              || paddr == ADDR_POS || paddr == ADDR_IRQ_STAT
                              || paddr == ADDR_IRQ_EN || paddr == ADDR_IRQ_CLR
                              || paddr == ADDR_DIV);
    assign irq     = |(s_r.ev & s_r.en);

    // R08 R10: error line always; drive withdrawn too if selected
    assign out_a          = s_r.opos[1];
    assign out_b          = s_r.opos[0];
    assign out_index      = s_r.idx; // R08
    assign out_error_n    = !s_r.err; // R10
    assign out_drive_oe_n = s_r.err && s_r.ctrl[CTRL_ERR_MODE]; // R10
    assign ana_sel        = s_r.ctrl[CTRL_OUT_FMT]; // R07
    assign ana_phase      = s_r.opos;
endmodule : rmqo_top

// *** sim/rmqo_enc_model.sv ***
// Encoder stand-in: one quadrature step per cycle while run is high.
// Assumes the bench drives run, up and idx_req just after pclk edges.
module rmqo_enc_model (
    input  wire logic pclk,
    input  wire logic run,
    input  wire logic up,
    input  wire logic idx_req,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_index
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph    = 2'h0;
    logic       idx_r = 1'b0;
    assign enc_index = idx_r;
    assign enc_a = ph[1] ^ ph[0];
    assign enc_b = ph[1];
    always @(posedge pclk) begin
        if (run) begin
            ph <= up ? ph + 2'h1 : ph - 2'h1;
        end
        // Moves with a step edge, so it spans a transition while running
        idx_r <= idx_req;
    end
endmodule : rmqo_enc_model

// *** sim/rmqo_monitor.sv ***
// Pin-level checks on the reference mark / quadrature output block.
// Assumes binding into rmqo_top; one pclk domain, presetn async low.
module rmqo_monitor
    import rmqo_pkg::*;
#(
    parameter int unsigned LOCKOUT_CYCLES = LOCKOUT_CYC,
    parameter int unsigned CLR_MIN_CYCLES = RESET_MIN_CYC
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       enc_a,
    input wire logic       enc_b,
    input wire logic       err_clear_n,
    input wire logic       out_a,
    input wire logic       out_b,
    input wire logic       out_index,
    input wire logic       out_error_n,
    input wire logic       out_drive_oe_n,
    input wire logic [1:0] ana_phase
);
    logic [1:0]  ab_r;
    int unsigned idx_gap_r;
    int unsigned edge_gap_r;
    int unsigned low_r;

    // Gaps saturate so long idle spans cannot wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ab_r       <= 2'h0;
            idx_gap_r  <= LOCKOUT_CYCLES;
            edge_gap_r <= 32'hFF;
            low_r      <= 0;
        end else begin
            ab_r       <= {enc_a, enc_b};
            idx_gap_r  <= out_index ? 0 : idx_gap_r + (idx_gap_r < LOCKOUT_CYCLES);
            edge_gap_r <= ({enc_a, enc_b} != ab_r) ? 0 : edge_gap_r + (edge_gap_r < 32'hFF);
            low_r      <= err_clear_n ? 0 : low_r + 1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access; psel && penable; endsequence
    sequence s_pulse; out_index ##1 !out_index; endsequence

    a_apb_ready: assert property (s_access |-> pready) else $error("apb answer late");
    a_slverr_map: assert property (s_access ##0 (paddr > 8'h18) |-> pslverr)
        else $error("unmapped access not refused");
    a_index_pulse: assert property (out_index |-> s_pulse) else $error("index too long");
    a_index_lock: assert property (out_index |-> idx_gap_r >= LOCKOUT_CYCLES - 2)
        else $error("index inside lockout");
    a_index_moving: assert property (out_index |-> edge_gap_r <= 4)
        else $error("index without motion");
    a_gray_out: assert property (!($changed(out_a) && $changed(out_b)))
        else $error("output jumped two phases");
    a_error_freeze: assert property (!out_error_n && $past(out_error_n) == 1'b0 |->
        $stable({out_a, out_b})) else $error("outputs moved in error");
    a_oe_error: assert property (out_drive_oe_n |-> !out_error_n)
        else $error("drive withdrawn without error");
    a_clear_hold: assert property ($rose(out_error_n) |-> low_r >= CLR_MIN_CYCLES - 1)
        else $error("error cleared too soon");
    a_ana_phase: assert property (ana_phase == {out_a, out_b})
        else $error("analogue phase mismatch");
endmodule : rmqo_monitor

bind rmqo_top rmqo_monitor #(
    .LOCKOUT_CYCLES (LOCKOUT_CYCLES),
    .CLR_MIN_CYCLES (CLR_MIN_CYCLES)
) mon_u (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .paddr          (paddr),
    .pready         (pready),
    .pslverr        (pslverr),
    .enc_a          (enc_a),
    .enc_b          (enc_b),
    .err_clear_n    (err_clear_n),
    .out_a          (out_a),
    .out_b          (out_b),
    .out_index      (out_index),
    .out_error_n    (out_error_n),
    .out_drive_oe_n (out_drive_oe_n),
    .ana_phase      (ana_phase)
);

// *** sim/tb.sv ***
// Self-checking bench: APB master, encoder model, reference and error cases.
// Assumes rmqo_top, the encoder model and the bound monitor are compiled.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb
    import rmqo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, p0;
    logic        enc_a, enc_b, m_idx, src, enc_fault, err_clear_n, run, up, idx_req;
    logic        out_a, out_b, out_index, out_error_n, out_drive_oe_n, ana_sel, irq;
    logic [1:0]  ana_phase;
    logic [1:0]  po = 2'h0;
    int          failures, check_count, n, d;
    int          ostep = 0;

    rmqo_top #(.LOCKOUT_CYCLES(50), .CLR_MIN_CYCLES(20)) dut_u (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .enc_a          (enc_a),
        .enc_b          (enc_b),
        .enc_index      (src ? 1'b0 : m_idx),
        .ref_switch     (src ? m_idx : 1'b0),
        .err_clear_n    (err_clear_n),
        .enc_fault      (enc_fault),
        .out_a          (out_a),
        .out_b          (out_b),
        .out_index      (out_index),
        .out_error_n    (out_error_n),
        .out_drive_oe_n (out_drive_oe_n),
        .ana_sel        (ana_sel),
        .ana_phase      (ana_phase),
        .irq            (irq)
    );
    rmqo_enc_model enc_u (.pclk, .run, .up, .idx_req, .enc_a, .enc_b, .enc_index(m_idx));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        po <= {out_a, out_b};
        if ({out_a, out_b} !== po) ostep <= ostep + 1;
    end

    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Holds the trigger until the interrupt answers, then reads events
    task refer();
        idx_req <= 1'b1;
        do @(posedge pclk); while (irq !== 1'b1);
        idx_req <= 1'b0;
        apb(0, ADDR_IRQ_STAT, 0);
    endtask : refer

    task results();
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    initial begin
        #1ms;
        failures++;
        results();
    end

    initial begin
        {psel, penable, pwrite, run, up, idx_req, src, enc_fault} = '0;
        {paddr, pwdata, failures, check_count} = '0;
        err_clear_n = 1'b1;
        presetn = 1'b0;
        rd = $urandom(32'h8310);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("error_n", 1'b1, out_error_n)
        apb(0, ADDR_CTRL, 0);
        `CHK("ctrl", 32'h100, rd)
        apb(0, 8'h3C, 0);
        p0 = $urandom & 32'hFF;
        apb(1, ADDR_DIV, p0);
        apb(0, ADDR_DIV, 0);
        `CHK("div", p0, rd)
        apb(1, ADDR_IRQ_EN, 32'hF);
        for (int s = 0; s < 2; s++) begin
            apb(1, ADDR_CTRL, 32'h100 | s);
            src <= s[0];
            run <= 1'b1;
            repeat (80) @(posedge pclk);
            apb(1, ADDR_IRQ_CLR, 32'hF);
            refer();
            `CHK("ref taken", 32'h1, rd)
            apb(1, ADDR_IRQ_CLR, 32'h1);
            repeat (2) @(posedge pclk);
            `CHK("irq", 1'b0, irq)
            refer();
            `CHK("ref locked", 32'h4, rd)
        end
        run <= 1'b0;
        repeat (4200) @(posedge pclk);
        apb(1, ADDR_IRQ_CLR, 32'hF);
        refer();
        `CHK("ref still", 32'h8, rd)
        for (int sel = 0; sel < 3; sel++) begin
            apb(1, ADDR_CTRL, 32'h100 | sel << 4 | sel << 2 | 32'(sel == 1) << 1);
            @(posedge pclk);
            `CHK("ana_sel", sel == 1, ana_sel)
            n = ($urandom % 6 + 1) << sel;
            up <= 1'($urandom % 2);
            apb(0, ADDR_POS, 0);
            p0 = rd;
            d = ostep;
            for (int i = 0; i < n; i++) begin
                run <= 1'b1;
                @(posedge pclk);
                if ($urandom % 2) begin
                    run <= 1'b0;
                    @(posedge pclk);
                end
            end
            run <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(0, ADDR_POS, 0);
            `CHK("pos", up ? n : -n, rd - p0)
            d = ostep - d;
            `CHK("out steps", n >> sel, d)
            `CHK("enc type", 1'b1, out_error_n)
        end
        for (int c = 0; c < 2; c++) begin
            apb(1, ADDR_CTRL, c ? 32'h18C : 32'h180);
            enc_fault <= (c == 0);
            repeat (3) @(posedge pclk);
            enc_fault <= 1'b0;
            apb(1, ADDR_CTRL, 32'h180);
            `CHK("drive off", 1'b1, out_drive_oe_n)
            err_clear_n <= 1'b0;
            repeat (5) @(posedge pclk);
            err_clear_n <= 1'b1;
            @(posedge pclk);
            `CHK("short clear", 1'b0, out_error_n)
            err_clear_n <= 1'b0;
            repeat (25) @(posedge pclk);
            err_clear_n <= 1'b1;
            @(posedge pclk);
            `CHK("cleared", 1'b1, out_error_n)
        end
        apb(0, ADDR_IRQ_STAT, 0);
        `CHK("err event", 1'b1, rd[1])
        results();
    end
endmodule : tb
